// File: pkg/master_sel_pkg.sv
// Shared constants and types for the dual master selector register bank.
package master_sel_pkg;

	// Register indices as selected by the low pointer bits.
	localparam logic [1:0] IDX_IRQ_MASK = 2'h0;
	localparam logic [1:0] IDX_CTRL = 2'h1;

	// Field positions of the interrupt mask register.
	localparam int MSK_DOWNSTREAM = 0;
	localparam int MSK_INIT_DONE = 1;

	// Field positions of the channel control register.
	localparam int CTL_PEER_TEST = 7;
	localparam int CTL_OWN_TEST = 6;
	localparam int CTL_RECOVERY = 4;
	localparam int CTL_PEER_CONNECT = 3;
	localparam int CTL_OWN_CONNECT = 2;
	localparam int CTL_PEER_OWNER = 1;
	localparam int CTL_OWN_OWNER = 0;

	// Writable bits and reset values.
	localparam logic [7:0] CTL_WRITE_MASK = 8'hD5;
	localparam logic [1:0] MASK_RESET = 2'h0;
	localparam logic [7:0] CTRL_RESET = 8'h00;

	// Pointer byte auto increment bit and default slave address.
	localparam int PTR_AI_BIT = 4;
	localparam logic [6:0] I2C_ADDR_DEFAULT = 7'h70;

	// Register write strobe handed from a port to the bank.
	typedef struct packed {
		logic en;
		logic [1:0] idx;
		logic [7:0] data;
	} reg_wr_type;

	// Serial port states.
	typedef enum logic [2:0] {
		SL_IDLE = 3'b000,
		SL_ADDR = 3'b001,
		SL_PTR = 3'b010,
		SL_WR = 3'b011,
		SL_RD = 3'b100
	} slave_state_type;

	// Channel switch states.
	typedef enum logic [1:0] {
		SW_IDLE = 2'b00,
		SW_RECOVER = 2'b01,
		SW_WAIT = 2'b10
	} sw_state_type;

endpackage

// File: design/i2c_reg_port.sv
// Two-wire serial slave port giving one upstream master its register access.
`timescale 1ns/1ps
module i2c_reg_port #(
	parameter logic [6:0] DEV_ADDR = master_sel_pkg::I2C_ADDR_DEFAULT
) (
	input wire logic ref_clk, // System clock.
	input wire logic arst_n, // Asynchronous reset, active low.
	input wire logic scl_i, // Serial clock pin level.
	input wire logic sda_i, // Serial data pin level.
	output logic sda_o, // Serial data drive level, always low.
	output logic sda_oe, // Serial data pull-down enable.
	input wire logic [7:0] rd_data, // Read data of the pointed register.
	output logic [1:0] rd_idx, // Current register pointer.
	output master_sel_pkg::reg_wr_type wr, // Register write strobe.
	output logic stop_seen // One-cycle pulse on a STOP condition.
);
	import master_sel_pkg::*;

	logic [1:0] scl_sync_q, scl_sync_d, sda_sync_q, sda_sync_d;
	logic scl_last_q, scl_last_d, sda_last_q, sda_last_d;
	logic scl_s, sda_s, rise, fall, start, stop;
	slave_state_type st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic [7:0] sh_q, sh_d, tx_q, tx_d;
	logic ack_q, ack_d, drv_q, drv_d, ai_q, ai_d, stop_q, stop_d;
	logic [1:0] idx_q, idx_d;
	reg_wr_type wr_q, wr_d;

	// Pin synchronisers and one sample of history for edge detection.
	always_comb begin
		scl_sync_d = {scl_sync_q[0], scl_i};
		sda_sync_d = {sda_sync_q[0], sda_i};
		scl_last_d = scl_sync_q[1];
		sda_last_d = sda_sync_q[1];
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			scl_sync_q <= 2'h3;
			sda_sync_q <= 2'h3;
			scl_last_q <= 1'b1;
			sda_last_q <= 1'b1;
		end else begin
			scl_sync_q <= scl_sync_d;
			sda_sync_q <= sda_sync_d;
			scl_last_q <= scl_last_d;
			sda_last_q <= sda_last_d;
		end
	end

	// Bus events seen on the synchronised levels.
	assign scl_s = scl_sync_q[1];
	assign sda_s = sda_sync_q[1];
	assign rise = scl_s & ~scl_last_q;
	assign fall = ~scl_s & scl_last_q;
	assign start = scl_s & scl_last_q & sda_last_q & ~sda_s;
	assign stop = scl_s & scl_last_q & ~sda_last_q & sda_s;

	// Byte framing, acknowledge and register pointer handling.
	always_comb begin
		st_d = st_q;
		cnt_d = cnt_q;
		sh_d = sh_q;
		tx_d = tx_q;
		ack_d = ack_q;
		drv_d = drv_q;
		ai_d = ai_q;
		idx_d = idx_q;
		wr_d = wr_q;
		wr_d.en = 1'b0;
		stop_d = stop;
		if (stop) begin
			st_d = SL_IDLE;
			ack_d = 1'b0;
			drv_d = 1'b0;
		end else if (start) begin
			st_d = SL_ADDR;
			cnt_d = 4'h0;
			ack_d = 1'b0;
			drv_d = 1'b0;
		end else if (st_q != SL_IDLE) begin
			if (rise) begin
				if (!ack_q) begin
					sh_d = {sh_q[6:0], sda_s};
					cnt_d = cnt_q + 4'h1;
					tx_d = {tx_q[6:0], 1'b1};
				end else if (st_q == SL_WR) begin
					// Registers update on the rising edge of the ack clock.
					wr_d.en = 1'b1;
					wr_d.idx = idx_q;
					wr_d.data = sh_q;
					if (ai_q) begin
						idx_d = idx_q + 2'h1;
					end
				end else if (st_q == SL_RD) begin
					if (sda_s) begin
						st_d = SL_IDLE;
					end else if (ai_q) begin
						idx_d = idx_q + 2'h1;
					end
				end
			end else if (fall) begin
				if (ack_q) begin
					ack_d = 1'b0;
					cnt_d = 4'h0;
					drv_d = 1'b0;
					if (st_q == SL_ADDR) begin
						st_d = sh_q[0] ? SL_RD : SL_PTR;
					end else if (st_q == SL_PTR) begin
						idx_d = sh_q[1:0];
						ai_d = sh_q[PTR_AI_BIT];
						st_d = SL_WR;
					end
					if ((st_q == SL_ADDR && sh_q[0]) || st_q == SL_RD) begin
						tx_d = rd_data;
						drv_d = ~rd_data[7];
					end
				end else if (cnt_q == 4'h8) begin
					ack_d = 1'b1;
					drv_d = (st_q != SL_RD);
					if (st_q == SL_ADDR && sh_q[7:1] != DEV_ADDR) begin
						st_d = SL_IDLE;
						drv_d = 1'b0;
					end
				end else if (st_q == SL_RD) begin
					drv_d = ~tx_q[7];
				end
			end
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_q <= SL_IDLE;
			cnt_q <= 4'h0;
			sh_q <= 8'h00;
			tx_q <= 8'hFF;
			ack_q <= 1'b0;
			drv_q <= 1'b0;
			ai_q <= 1'b0;
			idx_q <= 2'h0;
			wr_q <= '0;
			stop_q <= 1'b0;
		end else begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			sh_q <= sh_d;
			tx_q <= tx_d;
			ack_q <= ack_d;
			drv_q <= drv_d;
			ai_q <= ai_d;
			idx_q <= idx_d;
			wr_q <= wr_d;
			stop_q <= stop_d;
		end
	end

	// Port outputs.
	assign sda_o = 1'b0;
	assign sda_oe = drv_q;
	assign rd_idx = idx_q;
	assign wr = wr_q;
	assign stop_seen = stop_q;

endmodule

// File: design/dual_master_selector_regs.sv
// Per-master register bank and channel switch control of the master selector.
//
// How it works
// - With a recovery requested and its init mask clear, a master gets an interrupt when recovery ends.
// - With the init mask set, recovery and switch still happen but no interrupt is raised.
// - When recovery is requested the switch waits until the recovery sequence is done.
// - The downstream interrupt reaches a master's interrupt output unless its mask bit is set.
// - All interrupt mask bits reset to zero in every variant.
// - Each master has its own mask and control copy at the same register index.
// - The peer test bit pulls the other master's interrupt line low while set.
// - The own test bit pulls the writing master's interrupt line low while set.
// - The recovery request bit is writable, resets to zero and starts recovery before a switch.
// - The read-only peer connect bit and writable own connect bit together decide the connection.
// - The read-only peer owner bit and writable own owner bit together select the owner.
// - Peer bits ignore writes and their reset values follow the variant and master.
// - A master reads the connection as on when its connect pair differs.
// - A master reads that it owns the bus when its owner pair is equal.
// - The connection changes only on a STOP from the master that wrote its control copy.
// - With both masters requesting, the first STOP from either applies both control copies and clears both requests.
`timescale 1ns/1ps
module dual_master_selector_regs #(
	parameter logic [6:0] ADDR0 = master_sel_pkg::I2C_ADDR_DEFAULT,
	parameter logic [6:0] ADDR1 = master_sel_pkg::I2C_ADDR_DEFAULT,
	parameter logic CONNECT_AT_RESET = 1'b0
) (
	input wire logic ref_clk, // System clock, 25 MHz.
	input wire logic arst_n, // Asynchronous reset, active low.
	input wire logic [1:0] scl_i, // Upstream serial clock levels.
	input wire logic [1:0] sda_i, // Upstream serial data levels.
	output logic [1:0] sda_o, // Upstream data drive levels, low.
	output logic [1:0] sda_oe, // Upstream data pull-down enables.
	output logic [1:0] int_n_o, // Upstream interrupt drive levels, low.
	output logic [1:0] int_n_oe, // Upstream interrupt pull-down enables.
	input wire logic int_in_n, // Downstream interrupt pin, active low.
	output logic recovery_start, // Pulse asking the recovery sequencer.
	input wire logic recovery_done, // Pulse from sequencer when finished.
	output logic downstream_on, // Downstream channel connected.
	output logic downstream_sel // Master owning the downstream channel.
);
	import master_sel_pkg::*;

	// Reset value of master 0's copy; the connect bit follows the variant.
	localparam logic [7:0] CTRL0_RESET = CTRL_RESET | {5'h00,
		CONNECT_AT_RESET, 2'h0};

	reg_wr_type wr [2];
	logic [1:0] stop;
	logic [1:0][1:0] rd_idx;
	logic [1:0][7:0] rd_data;
	logic [1:0] peer_connect, peer_owner;
	logic [1:0][1:0] mask_q, mask_d;
	logic [1:0][7:0] ctrl_q, ctrl_d;
	logic [1:0] pend_q, pend_d, init_irq_q, init_irq_d;
	logic [1:0] int_oe_q, int_oe_d;
	logic [1:0] int_sync_q, int_sync_d;
	logic int_in_s;
	sw_state_type sw_q, sw_d;
	logic rec_m_q, rec_m_d, rec_start_q, rec_start_d;
	logic on_q, on_d, sel_q, sel_d;

	// Peer bits mirror the other copy; master 1 sees owner inverted.
	assign peer_connect[0] = ctrl_q[1][CTL_OWN_CONNECT];
	assign peer_connect[1] = ctrl_q[0][CTL_OWN_CONNECT];
	assign peer_owner[0] = ctrl_q[1][CTL_OWN_OWNER];
	assign peer_owner[1] = ~ctrl_q[0][CTL_OWN_OWNER];

	// One serial port and one readback view per upstream master.
	genvar m;
	generate
		for (m = 0; m < 2; m++) begin : g_port
			always_comb begin
				rd_data[m] = 8'h00;
				if (rd_idx[m] == IDX_IRQ_MASK) begin
					rd_data[m] = {6'h00, mask_q[m]};
				end else if (rd_idx[m] == IDX_CTRL) begin
					// Pairs read as on when they differ, owned when equal.
					rd_data[m] = {ctrl_q[m][7:6], 1'b0,
						ctrl_q[m][CTL_RECOVERY],
						peer_connect[m],
						ctrl_q[m][CTL_OWN_CONNECT],
						peer_owner[m],
						ctrl_q[m][CTL_OWN_OWNER]};
				end
			end

			i2c_reg_port #(
				.DEV_ADDR((m == 0) ? ADDR0 : ADDR1)
			) u_port (
				.ref_clk(ref_clk),
				.arst_n(arst_n),
				.scl_i(scl_i[m]),
				.sda_i(sda_i[m]),
				.sda_o(sda_o[m]),
				.sda_oe(sda_oe[m]),
				.rd_data(rd_data[m]),
				.rd_idx(rd_idx[m]),
				.wr(wr[m]),
				.stop_seen(stop[m])
			);
		end
	endgenerate

	// Register writes, STOP driven switching and interrupt generation.
	always_comb begin
		mask_d = mask_q;
		ctrl_d = ctrl_q;
		pend_d = pend_q;
		init_irq_d = init_irq_q;
		sw_d = sw_q;
		rec_m_d = rec_m_q;
		rec_start_d = 1'b0;
		on_d = on_q;
		sel_d = sel_q;
		int_sync_d = {int_sync_q[0], int_in_n};
		for (int i = 0; i < 2; i++) begin
			if (wr[i].en) begin
				if (wr[i].idx == IDX_IRQ_MASK) begin
					mask_d[i] = wr[i].data[1:0];
				end else if (wr[i].idx == IDX_CTRL) begin
					// Peer and unused bits are never stored.
					ctrl_d[i] = wr[i].data & CTL_WRITE_MASK;
					pend_d[i] = 1'b1;
					init_irq_d[i] = 1'b0;
				end
			end
		end
		case (sw_q)
			SW_IDLE: begin
				for (int i = 0; i < 2; i++) begin
					// Only a STOP from a master with its own request pending acts on the requests.
					if (stop[i] && pend_q[i]) begin
						for (int j = 0; j < 2; j++) begin
							// A control write in this cycle keeps its request.
							if (!wr[j].en || wr[j].idx != IDX_CTRL) begin
								pend_d[j] = 1'b0;
							end
						end
						if (ctrl_q[i][CTL_RECOVERY]) begin
							sw_d = SW_RECOVER;
							rec_m_d = i[0];
						end else begin
							// Copies hold the latest write of both.
							on_d = ctrl_q[0][CTL_OWN_CONNECT] ^
								ctrl_q[1][CTL_OWN_CONNECT];
							sel_d = ctrl_q[0][CTL_OWN_OWNER] ^
								ctrl_q[1][CTL_OWN_OWNER];
						end
					end
				end
			end
			SW_RECOVER: begin
				rec_start_d = 1'b1;
				sw_d = SW_WAIT;
			end
			SW_WAIT: begin
				if (recovery_done) begin
					on_d = ctrl_q[0][CTL_OWN_CONNECT] ^
						ctrl_q[1][CTL_OWN_CONNECT];
					sel_d = ctrl_q[0][CTL_OWN_OWNER] ^
						ctrl_q[1][CTL_OWN_OWNER];
					if (!mask_q[rec_m_q][MSK_INIT_DONE]) begin
						init_irq_d[rec_m_q] = 1'b1;
					end
					sw_d = SW_IDLE;
				end
			end
			default: begin
				sw_d = SW_IDLE;
			end
		endcase
		for (int i = 0; i < 2; i++) begin
			int_oe_d[i] = ctrl_q[i][CTL_OWN_TEST] |
				ctrl_q[i ^ 1][CTL_PEER_TEST] |
				(int_in_s & ~mask_q[i][MSK_DOWNSTREAM]) |
				init_irq_q[i];
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_q <= {MASK_RESET, MASK_RESET};
			ctrl_q <= {CTRL_RESET, CTRL0_RESET};
			pend_q <= 2'h0;
			init_irq_q <= 2'h0;
			sw_q <= SW_IDLE;
			rec_m_q <= 1'b0;
			rec_start_q <= 1'b0;
			on_q <= CONNECT_AT_RESET;
			sel_q <= 1'b0;
			int_oe_q <= 2'h0;
			int_sync_q <= 2'h3;
		end else begin
			mask_q <= mask_d;
			ctrl_q <= ctrl_d;
			pend_q <= pend_d;
			init_irq_q <= init_irq_d;
			sw_q <= sw_d;
			rec_m_q <= rec_m_d;
			rec_start_q <= rec_start_d;
			on_q <= on_d;
			sel_q <= sel_d;
			int_oe_q <= int_oe_d;
			int_sync_q <= int_sync_d;
		end
	end

	// Outputs; interrupt lines are open drain and only ever pulled low.
	assign int_in_s = ~int_sync_q[1];
	assign int_n_o = 2'h0;
	assign int_n_oe = int_oe_q;
	assign recovery_start = rec_start_q;
	assign downstream_on = on_q;
	assign downstream_sel = sel_q;

	default clocking @(posedge ref_clk); endclocking
	default disable iff (!arst_n);

	sequence s_wait_done;
		sw_q == SW_WAIT && recovery_done;
	endsequence

	// High in a cycle that is allowed to move the connection.
	logic switch_cause;
	assign switch_cause = (sw_q == SW_WAIT && recovery_done) ||
		(sw_q == SW_IDLE && |(stop & pend_q));

	property p_dn_irq_pass;
		(int_in_s && !mask_q[0][MSK_DOWNSTREAM]) |=> int_oe_q[0];
	endproperty
	a_dn_irq_pass: assert property (p_dn_irq_pass)
		else $error("Downstream interrupt not passed to master 0.");

	property p_dn_irq_block;
		(mask_q[1][MSK_DOWNSTREAM] && !ctrl_q[1][CTL_OWN_TEST] &&
			!ctrl_q[0][CTL_PEER_TEST] && !init_irq_q[1]) |=> !int_oe_q[1];
	endproperty
	a_dn_irq_block: assert property (p_dn_irq_block)
		else $error("Masked downstream interrupt reached master 1.");

	property p_peer_test;
		ctrl_q[1][CTL_PEER_TEST] |=> int_oe_q[0];
	endproperty
	a_peer_test: assert property (p_peer_test)
		else $error("Peer test bit did not pull master 0 line low.");

	property p_own_test;
		ctrl_q[1][CTL_OWN_TEST] |=> int_oe_q[1];
	endproperty
	a_own_test: assert property (p_own_test)
		else $error("Own test bit did not pull master 1 line low.");

	property p_recovery_start;
		sw_q == SW_RECOVER |=> recovery_start && sw_q == SW_WAIT;
	endproperty
	a_recovery_start: assert property (p_recovery_start)
		else $error("Recovery was not started.");

	property p_hold_during_recovery;
		(sw_q == SW_WAIT && !recovery_done) |=>
			($stable(on_q) && $stable(sel_q));
	endproperty
	a_hold_during_recovery: assert property (p_hold_during_recovery)
		else $error("Channel switched before recovery finished.");

	property p_init_irq;
		(s_wait_done ##0 !mask_q[rec_m_q][MSK_INIT_DONE]) |=>
			init_irq_q[rec_m_q] ##1 int_oe_q[rec_m_q];
	endproperty
	a_init_irq: assert property (p_init_irq)
		else $error("Init done interrupt missing.");

	property p_init_masked;
		$rose(init_irq_q[0]) |-> !$past(mask_q[0][MSK_INIT_DONE]);
	endproperty
	a_init_masked: assert property (p_init_masked)
		else $error("Masked init done interrupt raised.");

	property p_switch_on_stop;
		!switch_cause |=> ($stable(on_q) && $stable(sel_q));
	endproperty
	a_switch_on_stop: assert property (p_switch_on_stop)
		else $error("Connection changed without a STOP.");

	property p_copy_isolated;
		(wr[0].en && !wr[1].en) |=> $stable(ctrl_q[1]) && $stable(mask_q[1]);
	endproperty
	a_copy_isolated: assert property (p_copy_isolated)
		else $error("Master 0 write reached copy 1.");

	property p_peer_ro;
		wr[0].en |=> !ctrl_q[0][CTL_PEER_CONNECT] && !ctrl_q[0][CTL_PEER_OWNER];
	endproperty
	a_peer_ro: assert property (p_peer_ro)
		else $error("Peer bits stored from a write.");

endmodule

// File: testbench/i2c_master_model.sv
// Upstream two-wire bus master model that reaches one register port.
`timescale 1ns/1ps
module i2c_master_model #(
	parameter logic [6:0] ADDR = 7'h70
) (
	input wire logic ref_clk, // Clock that paces the bus phases.
	input wire logic sda_in, // Resolved data wire level.
	output logic scl, // Serial clock, stands high between frames.
	output logic sda_pd // Data pull-down, high pulls the wire low.
);
	int nacks = 0;

	// Both lines are released at time zero, so the wire idles high.
	initial begin
		scl = 1'b1;
		sda_pd = 1'b0;
	end

	// Waits a number of falling clock edges.
	task automatic tick(input int n);
		repeat (n) @(negedge ref_clk);
	endtask

	// Sends one bit and samples the wire late in the high phase.
	task automatic bit_io(input logic b, output logic r);
		tick(2);
		sda_pd = !b;
		tick(2);
		scl = 1'b1;
		tick(3);
		r = sda_in;
		tick(1);
		scl = 1'b0;
	endtask

	// Moves eight bits, then releases the wire for the ninth bit.
	task automatic byte_io(input logic [7:0] tx, output logic [7:0] rx,
		output logic a);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(1'b1, a);
	endtask

	// Sends a byte and counts a missing acknowledge.
	task automatic wbyte(input logic [7:0] tx);
		logic [7:0] rx;
		logic a;
		byte_io(tx, rx, a);
		if (a !== 1'b0) nacks++;
	endtask

	// Start or repeated start: data falls while the clock is high.
	task automatic start();
		tick(2);
		sda_pd = 1'b0;
		tick(2);
		scl = 1'b1;
		tick(4);
		sda_pd = 1'b1;
		tick(4);
		scl = 1'b0;
	endtask

	// Stop: data rises while the clock is high; the wire is then idle.
	task automatic stop();
		tick(2);
		sda_pd = 1'b1;
		tick(2);
		scl = 1'b1;
		tick(4);
		sda_pd = 1'b0;
		tick(8);
	endtask

	// Writes one register, with the stop left out when asked.
	task automatic wr(input logic [1:0] idx, input logic [7:0] d,
		input logic s);
		start();
		wbyte({ADDR, 1'b0});
		wbyte({6'h00, idx});
		wbyte(d);
		if (s) stop();
	endtask

	// Reads one register and ends the read with a not-acknowledge.
	task automatic rd(input logic [1:0] idx, output logic [7:0] d);
		logic a;
		start();
		wbyte({ADDR, 1'b0});
		wbyte({6'h00, idx});
		start();
		wbyte({ADDR, 1'b1});
		byte_io(8'hFF, d, a);
		stop();
	endtask
endmodule

// File: testbench/dual_master_selector_regs_tb.sv
// Self-checking bench for the dual master selector register bank.
`timescale 1ns/1ps
module dual_master_selector_regs_tb;
	import master_sel_pkg::*;
	logic ref_clk, arst_n, int_in_n, recovery_done;
	logic [1:0] scl, pd, sda_oe, int_n_oe, sda_wire, sda_lvl, int_lvl;
	logic recovery_start, downstream_on, downstream_sel;
	int mismatches = 0;
	int num_checks = 0;
	int rec_cnt = 0;
	logic [31:0] lfsr_q = 32'hBFF5A51B;
	logic [7:0] eq[$];
	logic [7:0] seen_v, r, r0;
	string nq[$];
	event res_ev;

	dual_master_selector_regs dual_master_selector_regs_i (
		.ref_clk(ref_clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_wire),
		.sda_o(sda_lvl), .sda_oe(sda_oe), .int_n_o(int_lvl),
		.int_n_oe(int_n_oe),
		.int_in_n(int_in_n), .recovery_start(recovery_start),
		.recovery_done(recovery_done), .downstream_on(downstream_on),
		.downstream_sel(downstream_sel));
	i2c_master_model m0 (.ref_clk(ref_clk), .sda_in(sda_wire[0]),
		.scl(scl[0]), .sda_pd(pd[0]));
	i2c_master_model m1 (.ref_clk(ref_clk), .sda_in(sda_wire[1]),
		.scl(scl[1]), .sda_pd(pd[1]));

	// Open-drain data wires with pull-ups; an enabled driver shows its level.
	assign sda_wire = ~pd & (~sda_oe | sda_lvl);

	// Free-running 25 MHz clock.
	initial begin
		ref_clk = 1'b0;
		forever #20 ref_clk = ~ref_clk;
	end

	// Counts recovery requests seen from the design.
	always @(posedge ref_clk) begin
		if (recovery_start === 1'b1) rec_cnt++;
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction

	task automatic check(string n, logic [7:0] s, logic [7:0] e);
		num_checks++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", n, e, s);
		end
	endtask

	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask

	// Each result takes the oldest expectation off the queue.
	initial forever begin
		@(res_ev);
		if (eq.size() > 0)
			check(nq.pop_front(), seen_v, eq.pop_front());
		else
			mismatches++;
	end

	task automatic note(string n, logic [7:0] e);
		nq.push_back(n);
		eq.push_back(e);
	endtask

	task automatic post(logic [7:0] s);
		seen_v = s;
		-> res_ev;
		#1;
	endtask

	// Snapshot of {interrupt levels, on, sel, interrupt enables}.
	task automatic outs(logic [3:0] e);
		note("outputs", {4'h0, e});
		post({2'h0, int_lvl, downstream_on, downstream_sel, int_n_oe});
	endtask

	task automatic rd(input int m, input logic [1:0] i, input logic [7:0] e);
		note("read", e);
		if (m == 1) m1.rd(i, r);
		else m0.rd(i, r);
		post(r);
	endtask

	task automatic wr(input int m, input logic [1:0] i, input logic [7:0] d,
		input logic s);
		if (m == 1) m1.wr(i, d, s);
		else m0.wr(i, d, s);
	endtask

	// Waits for the n-th request, acts as the sequencer, checks both sides.
	task automatic recover(int n, logic [3:0] pre, logic [3:0] post_v);
		for (int i = 0; i < 200 && rec_cnt < n; i++) @(negedge ref_clk);
		if (rec_cnt < n) begin
			mismatches++;
			end_sim();
		end
		repeat (20) @(negedge ref_clk);
		outs(pre);
		recovery_done = 1'b1;
		@(negedge ref_clk);
		recovery_done = 1'b0;
		repeat (4) @(negedge ref_clk);
		outs(post_v);
	endtask

	// Main sequence, inputs changed on falling edges.
	initial begin
		arst_n = 1'b0;
		int_in_n = 1'b1;
		recovery_done = 1'b0;
		repeat (16) @(posedge ref_clk);
		@(negedge ref_clk);
		arst_n = 1'b1;
		repeat (4) @(negedge ref_clk);
		outs(4'b0000);
		rd(0, IDX_IRQ_MASK, 8'h00);
		rd(1, IDX_IRQ_MASK, 8'h00);
		rd(0, IDX_CTRL, 8'h00);
		rd(1, IDX_CTRL, 8'h02);
		rd(0, 2'h2, 8'h00);
		for (int i = 0; i < 3; i++) begin
			lfsr_q = lfsr(lfsr_q);
			r0 = lfsr_q[7:0];
			wr(0, IDX_IRQ_MASK, r0, 1'b1);
			lfsr_q = lfsr(lfsr_q);
			wr(1, IDX_IRQ_MASK, lfsr_q[7:0], 1'b1);
			rd(0, IDX_IRQ_MASK, r0 & 8'h03);
			rd(1, IDX_IRQ_MASK, lfsr_q[7:0] & 8'h03);
		end
		wr(0, IDX_IRQ_MASK, 8'h00, 1'b1);
		wr(1, IDX_IRQ_MASK, 8'h00, 1'b1);
		wr(0, IDX_CTRL, 8'h40, 1'b1);
		outs(4'b0001);
		wr(0, IDX_CTRL, 8'hAA, 1'b1);
		outs(4'b0010);
		rd(0, IDX_CTRL, 8'h80);
		wr(1, IDX_CTRL, 8'h80, 1'b1);
		outs(4'b0011);
		wr(0, IDX_CTRL, 8'h00, 1'b1);
		wr(1, IDX_CTRL, 8'h00, 1'b1);
		outs(4'b0000);
		wr(0, IDX_CTRL, 8'h04, 1'b1);
		outs(4'b1000);
		rd(0, IDX_CTRL, 8'h04);
		rd(1, IDX_CTRL, 8'h0A);
		wr(1, IDX_CTRL, 8'h01, 1'b0);
		rd(0, IDX_CTRL, 8'h06);
		outs(4'b1000);
		m1.stop();
		outs(4'b1100);
		wr(0, IDX_IRQ_MASK, 8'h02, 1'b1);
		wr(0, IDX_CTRL, 8'h15, 1'b1);
		recover(1, 4'b1100, 4'b1000);
		wr(1, IDX_CTRL, 8'h10, 1'b1);
		recover(2, 4'b1000, 4'b1110);
		wr(1, IDX_CTRL, 8'h00, 1'b1);
		outs(4'b1100);
		note("recoveries", 8'h02);
		post(rec_cnt[7:0]);
		wr(0, IDX_IRQ_MASK, 8'h03, 1'b1);
		int_in_n = 1'b0;
		repeat (5) @(negedge ref_clk);
		outs(4'b1110);
		wr(0, IDX_IRQ_MASK, 8'h02, 1'b1);
		outs(4'b1111);
		int_in_n = 1'b1;
		repeat (5) @(negedge ref_clk);
		outs(4'b1100);
		note("nacks", 8'h00);
		post(8'(m0.nacks + m1.nacks));
		end_sim();
	end
endmodule
